// file: rtl/nerr_pkg.sv
package nerr_pkg;
   // register byte offsets
   localparam logic [11:0] OFF_PARITY_1     = 12'h010;
   localparam logic [11:0] OFF_STATUS_UPPER = 12'h014;
   localparam logic [11:0] OFF_PARITY_2     = 12'h018;
   localparam logic [11:0] OFF_PARITY_15    = 12'h04C;
   localparam logic [11:0] OFF_MODE         = 12'h1B0;
   // mode register fields
   localparam int          MODE_SWRST_BIT   = 8;
   localparam int          CT_RS_BIT        = 2;
   localparam logic [2:0]  CT_PAGE          = 3'h0;
   localparam logic [2:0]  CT_S256          = 3'h1;
   localparam logic [2:0]  CT_S512          = 3'h2;
   localparam logic [2:0]  MODE_RESET       = 3'h0;
   // parity word field positions
   localparam int          WORD_LSB         = 3;
   localparam int          S256_PAR_LSB     = 12;
   localparam int          S512_PAR_LSB     = 12;
   // status layout
   localparam logic [31:0] SR2_RESET        = 32'h00000000;
   localparam logic [31:0] SR2_RSVD_MASK    = 32'h88888888;
   localparam logic [3:0]  FLAG_FIRST_SEC   = 4'h8;
   localparam int          NIB_REC          = 0;
   localparam int          NIB_SINGLE       = 1;
   localparam int          NIB_MULTI        = 2;
   // parity storage
   localparam int          MEM_AW           = 5;
   localparam logic [3:0]  PARITY_FIRST     = 4'h1;
   localparam logic [3:0]  PARITY_LAST      = 4'hF;
   localparam logic [31:0] PARITY_RESET     = 32'h00000000;
   // bus answers
   localparam logic [1:0]  RESP_OKAY        = 2'h0;
   localparam logic [1:0]  RESP_SLVERR      = 2'h2;

   // one sector result from the hamming engine
   typedef struct packed {
      logic [3:0]  idx;
      logic [15:0] parity;
      logic [8:0]  word;
      logic [2:0]  bitpos;
      logic [2:0]  err_cnt;
   } nerr_sector_s;

   // one reed-solomon pass result
   typedef struct packed {
      logic [2:0] count;
      logic       fail;
   } nerr_rs_s;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_COPY = 3'b010,
      ST_LAST = 3'b100
   } nerr_commit_e;
endpackage

// file: rtl/nerr_parity_mem.sv
`timescale 1ns/1ns
module nerr_parity_mem
(
   // clock and reset
   input  wire logic                       aclk,
   input  wire logic                       aresetn,
   // write port
   input  wire logic                       we,
   input  wire logic [nerr_pkg::MEM_AW-1:0] waddr,
   input  wire logic [31:0]                wdata,
   // read port
   input  wire logic [nerr_pkg::MEM_AW-1:0] raddr,
   output logic      [31:0]                rdata_q
);
   import nerr_pkg::*;

   logic [31:0] mem [2**MEM_AW];

   // no reset on the array; validity masks above hide stale words
   always_ff @(posedge aclk)
   begin
      if (we)
         mem[waddr] <= wdata;
   end

   // registered read data
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         rdata_q <= PARITY_RESET;
      else
         rdata_q <= mem[raddr];
   end
endmodule

// file: rtl/nerr_top.sv
`timescale 1ns/1ns
module nerr_top
(
   // clock and reset
   input  wire logic                 aclk,
   input  wire logic                 aresetn,
   // axi4-lite write address
   input  wire logic [11:0]          s_axi_awaddr,
   input  wire logic                 s_axi_awvalid,
   output logic                      s_axi_awready,
   // axi4-lite write data
   input  wire logic [31:0]          s_axi_wdata,
   input  wire logic [3:0]           s_axi_wstrb,
   input  wire logic                 s_axi_wvalid,
   output logic                      s_axi_wready,
   // axi4-lite write response
   output logic [1:0]                s_axi_bresp,
   output logic                      s_axi_bvalid,
   input  wire logic                 s_axi_bready,
   // axi4-lite read address
   input  wire logic [11:0]          s_axi_araddr,
   input  wire logic                 s_axi_arvalid,
   output logic                      s_axi_arready,
   // axi4-lite read data
   output logic [31:0]               s_axi_rdata,
   output logic [1:0]                s_axi_rresp,
   output logic                      s_axi_rvalid,
   input  wire logic                 s_axi_rready,
   // page command and completion from the controller
   input  wire logic                 page_cmd,
   input  wire logic                 page_done,
   // hamming sector results
   input  wire logic                 sec_valid,
   output logic                      sec_ready,
   input  wire nerr_pkg::nerr_sector_s sec_res,
   // reed-solomon results
   input  wire logic                 rs_valid,
   input  wire nerr_pkg::nerr_rs_s   rs_res,
   // mode toward the rest of the unit
   output logic [2:0]                correction_type
);
   import nerr_pkg::*;

   // every assertion runs on the bus clock and sleeps while reset is low
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   // mode register and soft reset
   logic [2:0]   corr_type_q;
   logic         swrst_q;
   // write channel state
   logic         aw_have_q;
   logic         w_have_q;
   logic [11:0]  awaddr_q;
   logic [31:0]  wdata_q;
   logic [3:0]   wstrb_q;
   logic         bvalid_q;
   logic [1:0]   bresp_q;
   // read channel state
   logic         rd_pend_q;
   logic [11:0]  araddr_q;
   logic         rvalid_q;
   logic [31:0]  rdata_q;
   logic [1:0]   rresp_q;
   // results
   logic [3:0]   stage_nib_q [8];
   logic [3:0]   vis_nib_q [8];
   logic [15:0]  stage_valid_q;
   logic [15:0]  vis_valid_q;
   logic         rs_multi_q;
   logic [2:0]   rs_count_q;
   // commit walk
   nerr_commit_e st_q;
   nerr_commit_e st_d;
   logic [3:0]   cnt_q;
   // memory port
   logic [31:0]  mem_rdata;

   // pack a sector result into the register layout of the active mode
   function automatic logic [31:0] fmt(input logic [2:0] ct, input nerr_sector_s r);
      logic [31:0] w;
      w = 32'h0;
      if (ct == CT_PAGE)
         w = 32'(r.parity);
      else if (ct == CT_S256)
         w = (32'(r.parity[10:0]) << S256_PAR_LSB) | (32'(r.word[7:0]) << WORD_LSB) | 32'(r.bitpos);
      else if (ct == CT_S512)
         w = (32'(r.parity[11:0]) << S512_PAR_LSB) | (32'(r.word) << WORD_LSB) | 32'(r.bitpos);
      return w;
   endfunction

   // map a parity register address to its number 1..15
   function automatic logic [3:0] par_index(input logic [11:0] a);
      logic [11:0] d;
      d = a - OFF_PARITY_2;
      if (a == OFF_PARITY_1)
         return PARITY_FIRST;
      return d[5:2] + 4'h2;
   endfunction

   // handshakes and status decode
   wire commit_idle = st_q == ST_IDLE;
   wire commit_fin  = st_q == ST_LAST;
   wire sec_go      = sec_valid && sec_ready;
   wire rs_mode     = corr_type_q[CT_RS_BIT];
   wire rs_go       = rs_valid && rs_mode;
   // sector flags only in sectored types
   wire flags_used  = corr_type_q == CT_S256 || corr_type_q == CT_S512;
   wire wr_go       = aw_have_q && w_have_q && !bvalid_q;
   wire wr_mode     = wr_go && awaddr_q == OFF_MODE;
   wire ar_go       = s_axi_arvalid && s_axi_arready;

   assign s_axi_awready   = !aw_have_q && !bvalid_q;
   assign s_axi_wready    = !w_have_q && !bvalid_q;
   // reads wait out a commit so software never sees half a page
   assign s_axi_arready   = !rd_pend_q && !rvalid_q && commit_idle;
   assign sec_ready       = commit_idle;
   assign s_axi_bvalid    = bvalid_q;
   assign s_axi_bresp     = bresp_q;
   assign s_axi_rvalid    = rvalid_q;
   assign s_axi_rdata     = rdata_q;
   assign s_axi_rresp     = rresp_q;
   assign correction_type = corr_type_q;

   // address capture and write response
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_have_q <= 1'b0;
         w_have_q  <= 1'b0;
         awaddr_q  <= 12'h000;
         wdata_q   <= 32'h0;
         wstrb_q   <= 4'h0;
         bvalid_q  <= 1'b0;
         bresp_q   <= RESP_OKAY;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_have_q <= 1'b1;
            awaddr_q  <= s_axi_awaddr;
         end
         else if (wr_go)
            aw_have_q <= 1'b0;
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_have_q <= 1'b1;
            wdata_q  <= s_axi_wdata;
            wstrb_q  <= s_axi_wstrb;
         end
         else if (wr_go)
            w_have_q <= 1'b0;
         if (wr_go)
         begin
            bvalid_q <= 1'b1;
            bresp_q  <= wr_mode ? RESP_OKAY : RESP_SLVERR; // result registers are read-only
         end
         else if (bvalid_q && s_axi_bready)
            bvalid_q <= 1'b0;
      end
   end

   // mode register; soft reset bit is a write-one pulse and reads zero
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         corr_type_q <= MODE_RESET;
         swrst_q     <= 1'b0;
      end
      else
      begin
         if (wr_mode && wstrb_q[0])
            corr_type_q <= wdata_q[2:0];
         swrst_q <= wr_mode && wstrb_q[1] && wdata_q[MODE_SWRST_BIT];
      end
   end

   // read decode on the captured address
   wire [3:0]  ra_idx   = par_index(araddr_q);
   wire        is_p1    = araddr_q == OFF_PARITY_1;
   wire        is_pn    = araddr_q >= OFF_PARITY_2 && araddr_q <= OFF_PARITY_15 && araddr_q[1:0] == 2'h0;
   wire        pr_hit   = is_p1 || is_pn;
   wire        is_sr2   = araddr_q == OFF_STATUS_UPPER;
   wire        is_mode  = araddr_q == OFF_MODE;
   wire [31:0] vis_flags;
   wire [31:0] stage_flags;
   // reed-solomon layout replaces the sector nibbles
   wire [31:0] sr2_val  = rs_mode ? {28'h0, rs_multi_q, rs_count_q} : vis_flags;
   // a parity word not yet filled reads as its reset value
   wire [31:0] pr_val   = vis_valid_q[ra_idx] ? mem_rdata : PARITY_RESET;
   wire [31:0] rd_mux   = pr_hit ? pr_val : is_sr2 ? sr2_val : is_mode ? {29'h0, corr_type_q} : 32'h0;
   wire        rd_ok    = pr_hit || is_sr2 || is_mode;

   // read pipeline: address and memory read on one edge, answer on the next
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         rd_pend_q <= 1'b0;
         araddr_q  <= 12'h000;
         rvalid_q  <= 1'b0;
         rdata_q   <= 32'h0;
         rresp_q   <= RESP_OKAY;
      end
      else
      begin
         rd_pend_q <= ar_go;
         if (ar_go)
            araddr_q <= s_axi_araddr;
         if (rd_pend_q)
         begin
            rvalid_q <= 1'b1;
            rdata_q  <= rd_mux;
            rresp_q  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
         end
         else if (rvalid_q && s_axi_rready)
            rvalid_q <= 1'b0;
      end
   end

   // per-sector flags for sectors 8..15
   genvar g;
   generate
      for (g = 0; g < 8; g++)
      begin : g_sec
         wire hit = sec_go && flags_used && sec_res.idx == (FLAG_FIRST_SEC + 4'(g));
         always_ff @(posedge aclk)
         begin
            if (!aresetn || swrst_q)
               stage_nib_q[g] <= 4'h0;
            // flags follow the error count, top bit reserved
            else if (hit)
               stage_nib_q[g] <= {1'b0, sec_res.err_cnt > 3'h1, sec_res.err_cnt == 3'h1, sec_res.err_cnt != 3'h0};
            else if (page_cmd)
               stage_nib_q[g] <= 4'h0;
         end
         // visible copy changes only at the end of a commit
         always_ff @(posedge aclk)
         begin
            if (!aresetn || swrst_q)
               vis_nib_q[g] <= 4'h0;
            else if (commit_fin)
               vis_nib_q[g] <= stage_nib_q[g];
         end
         assign vis_flags[4*g +: 4]   = vis_nib_q[g];
         assign stage_flags[4*g +: 4] = stage_nib_q[g];
      end
   endgenerate

   // staged and visible word validity; an arriving result beats a clear
   always_ff @(posedge aclk)
   begin
      if (!aresetn || swrst_q)
      begin
         stage_valid_q <= 16'h0000;
         vis_valid_q   <= 16'h0000;
      end
      else
      begin
         if (sec_go)
            stage_valid_q[sec_res.idx] <= 1'b1;
         else if (page_cmd)
            stage_valid_q <= 16'h0000;
         if (commit_fin)
            vis_valid_q <= stage_valid_q;
      end
   end

   // each pass reports one sub-page; a new pass overwrites the last
   always_ff @(posedge aclk)
   begin
      if (!aresetn || swrst_q)
      begin
         rs_multi_q <= 1'b0;
         rs_count_q <= 3'h0;
      end
      // fail means more than four errors, count then zero
      else if (rs_go)
      begin
         rs_multi_q <= rs_res.fail;
         rs_count_q <= rs_res.fail ? 3'h0 : rs_res.count;
      end
      else if (page_cmd)
      begin
         rs_multi_q <= 1'b0;
         rs_count_q <= 3'h0;
      end
   end

   // commit walk: copy staged words 1..15 to visible slots
   always_comb
   begin
      st_d = st_q;
      unique case (st_q)
         ST_IDLE: st_d = page_done ? ST_COPY : ST_IDLE;
         ST_COPY: st_d = (cnt_q == PARITY_LAST) ? ST_LAST : ST_COPY;
         ST_LAST: st_d = ST_IDLE;
         default: st_d = ST_IDLE;
      endcase
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         st_q  <= ST_IDLE;
         cnt_q <= PARITY_FIRST;
      end
      else
      begin
         st_q  <= st_d;
         cnt_q <= (st_q == ST_COPY) ? cnt_q + 4'h1 : PARITY_FIRST;
      end
   end

   // memory ports; the read lags one cycle so writes trail reads by one
   wire                copy_wr   = (st_q == ST_COPY && cnt_q != PARITY_FIRST) || commit_fin;
   wire [3:0]          copy_idx  = cnt_q - 4'h1;
   wire                mem_we    = copy_wr || sec_go;
   wire [MEM_AW-1:0]   mem_waddr = copy_wr ? {1'b1, copy_idx} : {1'b0, sec_res.idx};
   // layout by mode, location stored as the engine gives it
   wire [31:0]         mem_wdata = copy_wr ? mem_rdata : fmt(corr_type_q, sec_res);
   wire [MEM_AW-1:0]   mem_raddr = commit_idle ? {1'b1, par_index(s_axi_araddr)} : {1'b0, cnt_q};

   nerr_parity_mem u_mem
   (
      .aclk    (aclk),
      .aresetn (aresetn),
      .we      (mem_we),
      .waddr   (mem_waddr),
      .wdata   (mem_wdata),
      .raddr   (mem_raddr),
      .rdata_q (mem_rdata)
   );

   sequence commit_start_s;
      page_done && commit_idle ##1 !commit_idle;
   endsequence

   sr2_reserved_a: assert property (!rs_mode |-> (sr2_val & SR2_RSVD_MASK) == 32'h0)
      else $error("reserved status bit set");
   page_fmt_a: assert property (sec_go && corr_type_q == CT_PAGE |-> mem_wdata == {16'h0, sec_res.parity})
      else $error("page parity layout wrong");
   s256_fmt_a: assert property (sec_go && corr_type_q == CT_S256 |->
      mem_wdata[31:23] == 9'h0 && !mem_wdata[11] && mem_wdata[10:3] == sec_res.word[7:0])
      else $error("256-byte layout wrong");
   s512_fmt_a: assert property (sec_go && corr_type_q == CT_S512 |->
      mem_wdata[23:12] == sec_res.parity[11:0]
      && mem_wdata[11:3] == sec_res.word && mem_wdata[2:0] == sec_res.bitpos)
      else $error("512-byte layout wrong");
   multi_flag_a: assert property (sec_go && flags_used && sec_res.idx >= FLAG_FIRST_SEC && !swrst_q |=>
      stage_flags[{$past(sec_res.idx[2:0]), 2'h2}] == ($past(sec_res.err_cnt) > 3'h1))
      else $error("multi flag mismatch");
   single_flag_a: assert property (sec_go && flags_used && sec_res.idx >= FLAG_FIRST_SEC && !swrst_q |=>
      stage_flags[{$past(sec_res.idx[2:0]), 2'h1}] == ($past(sec_res.err_cnt) == 3'h1))
      else $error("single flag mismatch");
   rec_flag_a: assert property (sec_go && flags_used && sec_res.idx >= FLAG_FIRST_SEC && !swrst_q |=>
      stage_flags[{$past(sec_res.idx[2:0]), 2'h0}] == ($past(sec_res.err_cnt) != 3'h0))
      else $error("recoverable flag mismatch");
   mode_gate_a: assert property (!flags_used && !page_cmd && !swrst_q |=> $stable(stage_flags))
      else $error("flags moved outside sectored mode");
   rs_layout_a: assert property (rs_mode |-> sr2_val[31:4] == 28'h0 && sr2_val[3] == rs_multi_q)
      else $error("reed-solomon layout wrong");
   rs_fail_a: assert property (rs_go && rs_res.fail && !swrst_q |=> rs_multi_q && rs_count_q == 3'h0)
      else $error("uncorrectable not flagged");
   rs_count_a: assert property (rs_go && !rs_res.fail && !swrst_q |=>
      !rs_multi_q && rs_count_q == $past(rs_res.count))
      else $error("error count wrong");
   rs_clear_a: assert property ((page_cmd || swrst_q) && !rs_go |=> !rs_multi_q && rs_count_q == 3'h0)
      else $error("status not cleared");
   commit_len_a: assert property (commit_start_s |-> ##16 commit_idle)
      else $error("commit walk length wrong");
   commit_flags_a: assert property (commit_fin && !swrst_q |=> vis_flags == $past(stage_flags))
      else $error("visible flags not committed");
   rd_lat_a: assert property (ar_go |=> ##1 s_axi_rvalid)
      else $error("read answer late");
endmodule

// file: bench/nerr_nand_model.sv
`timescale 1ns/1ns
module nerr_nand_model
(
   // clock
   input  wire logic              aclk,
   // page command and completion pulses
   output logic                   page_cmd,
   output logic                   page_done,
   // hamming sector results
   output logic                   sec_valid,
   input  wire logic              sec_ready,
   output nerr_pkg::nerr_sector_s sec_res,
   // reed-solomon results
   output logic                   rs_valid,
   output nerr_pkg::nerr_rs_s     rs_res
);
   import nerr_pkg::*;

   // quiet at start; payload scrambled so stale data never looks meaningful
   initial
   begin
      page_cmd  = 1'b0;
      page_done = 1'b0;
      sec_valid = 1'b0;
      sec_res   = '1;
      rs_valid  = 1'b0;
      rs_res    = '1;
   end

   // one-cycle command or completion strobe
   task automatic pulse(input logic done);
      if (done)
         page_done <= 1'b1;
      else
         page_cmd <= 1'b1;
      @(posedge aclk);
      page_done <= 1'b0;
      page_cmd  <= 1'b0;
   endtask

   // offer one sector, optionally after idle cycles; valid stays up between beats sent with no gap
   task automatic send_sector(input nerr_sector_s s, input int gap);
      int n;
      if (gap > 0)
      begin
         sec_valid <= 1'b0;
         sec_res   <= ~sec_res;
         repeat (gap) @(posedge aclk);
      end
      sec_res   <= s;
      sec_valid <= 1'b1;
      n = 0;
      do
      begin
         @(posedge aclk);
         n++;
      end
      while (sec_ready !== 1'b1 && n < 100);
   endtask

   // end of a burst: drop valid and invert the released payload
   task automatic release_bus();
      sec_valid <= 1'b0;
      sec_res   <= ~sec_res;
      @(posedge aclk);
   endtask

   task automatic send_rs(input nerr_rs_s r);
      rs_res   <= r;
      rs_valid <= 1'b1;
      @(posedge aclk);
      rs_valid <= 1'b0;
      rs_res   <= ~r;
   endtask
endmodule

// file: bench/nerr_top_test.sv
`timescale 1ns/1ns
module nerr_top_test;
   import nerr_pkg::*;
   // bus and far-side signals
   logic         aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
   logic         arvalid, arready, rvalid, rready, page_cmd, page_done, sec_valid, sec_ready, rs_valid;
   logic [11:0]  awaddr, araddr;
   logic [31:0]  wdata, rdata, d, ef;
   logic [3:0]   wstrb;
   logic [1:0]   bresp, rresp, r;
   logic [2:0]   ctype;
   logic [2:0]   cts [5];
   nerr_sector_s sec_res, s;
   nerr_sector_s sq[$];
   nerr_rs_s     rs_res;
   int           num_errors, n_compared, seed_dummy;

   // design under test
   nerr_top u_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .page_cmd(page_cmd),
      .page_done(page_done), .sec_valid(sec_valid), .sec_ready(sec_ready), .sec_res(sec_res),
      .rs_valid(rs_valid), .rs_res(rs_res), .correction_type(ctype));

   // flash-side result source
   nerr_nand_model u_nand (.aclk(aclk), .page_cmd(page_cmd), .page_done(page_done), .sec_valid(sec_valid),
      .sec_ready(sec_ready), .sec_res(sec_res), .rs_valid(rs_valid), .rs_res(rs_res));

   // 100 MHz clock
   initial
   begin
      aclk = 1'b0;
      forever #5 aclk = ~aclk;
   end

   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // handshake selector: 0 arready, 1 rvalid, 2 bvalid
   function automatic logic hs(int k);
      return (k == 0) ? arready : (k == 1) ? rvalid : bvalid;
   endfunction

   // bounded wait for a handshake; a spent bound ends the run
   task automatic wait_for(input int k);
      int n;
      n = 0;
      do
      begin
         @(posedge aclk);
         n++;
      end
      while (hs(k) !== 1'b1 && n < 200);
      if (hs(k) !== 1'b1)
      begin
         check("handshake wait", 32'h0, 32'h1);
         end_of_test();
      end
   endtask

   // axi4-lite write; address and data released independently when taken
   task automatic wr(input logic [11:0] a, input logic [31:0] v, input logic [3:0] st, output logic [1:0] rsp);
      int   n;
      logic ad, dd;
      awaddr  <= a;
      wdata   <= v;
      wstrb   <= st;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      ad = 1'b0;
      dd = 1'b0;
      for (n = 0; n < 200 && !(ad && dd); n++)
      begin
         @(posedge aclk);
         ad = ad | (awready === 1'b1);
         dd = dd | (wready === 1'b1);
         if (ad)
            awvalid <= 1'b0;
         if (dd)
            wvalid <= 1'b0;
      end
      wait_for(2);
      rsp = bresp;
      bready <= 1'b0;
      // let an edge pass so a following call never re-drives bready in this step
      @(posedge aclk);
   endtask

   // axi4-lite read; rready held from the start until rvalid is seen
   task automatic rd(input logic [11:0] a, output logic [31:0] v, output logic [1:0] rsp);
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      wait_for(0);
      arvalid <= 1'b0;
      wait_for(1);
      v   = rdata;
      rsp = rresp;
      rready <= 1'b0;
      // let an edge pass so a following call never re-drives rready in this step
      @(posedge aclk);
   endtask

   // expected parity word for one sector under a correction type
   function automatic logic [31:0] exp_pr(logic [2:0] ct, nerr_sector_s x);
      if (ct == CT_S256)
         return {9'h0, x.parity[10:0], 1'b0, x.word[7:0], x.bitpos};
      if (ct == CT_S512)
         return {8'h0, x.parity[11:0], x.word, x.bitpos};
      return {16'h0, x.parity};
   endfunction

   // expected status nibble: reserved, multi, single, recoverable
   function automatic logic [3:0] nib(logic [2:0] c);
      return {1'b0, c > 3'h1, c == 3'h1, c != 3'h0};
   endfunction

   function automatic logic [11:0] paddr(int i);
      return (i == 1) ? OFF_PARITY_1 : OFF_PARITY_2 + 12'(4 * (i - 2));
   endfunction

   // main sequence
   initial
   begin
      {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
      {awaddr, araddr, wdata, wstrb} = '0;
      num_errors = 0;
      n_compared = 0;
      cts = '{CT_S256, CT_S512, CT_PAGE, 3'h3, CT_S512};
      seed_dummy = $urandom(51);
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (2) @(posedge aclk);
      for (int i = 0; i < 16; i++)
      begin
         rd(OFF_PARITY_1 + 12'(4 * i), d, r);
         check("reset word", d, (i == 1) ? SR2_RESET : PARITY_RESET);
         check("reset resp", {30'h0, r}, {30'h0, RESP_OKAY});
      end
      wr(OFF_PARITY_2, 32'hFFFFFFFF, 4'hF, r);
      check("ro write resp", {30'h0, r}, {30'h0, RESP_SLVERR});
      rd(OFF_PARITY_2, d, r);
      check("ro word kept", d, PARITY_RESET);
      rd(12'h100, d, r);
      check("unmapped resp", {30'h0, r}, {30'h0, RESP_SLVERR});
      for (int k = 0; k < 5; k++)
      begin
         wr(OFF_MODE, {29'h0, cts[k]}, 4'h1, r);
         check("mode write resp", {30'h0, r}, {30'h0, RESP_OKAY});
         check("correction type", {29'h0, ctype}, {29'h0, cts[k]});
         u_nand.pulse(1'b0);
         ef = SR2_RESET;
         sq.delete();
         for (int i = 1; i < 16; i++)
         begin
            s.idx     = 4'(i);
            s.parity  = 16'($urandom);
            s.word    = (i == 14) ? 9'h1FF : 9'($urandom);
            s.bitpos  = 3'($urandom);
            s.err_cnt = (i == 15) ? 3'h7 : 3'($urandom_range(0, 3));
            u_nand.send_sector(s, int'($urandom_range(0, 2)));
            sq.push_back(s);
            if (i >= 8 && (cts[k] == CT_S256 || cts[k] == CT_S512))
               ef[4 * (i - 8) +: 4] = nib(s.err_cnt);
         end
         u_nand.release_bus();
         rd(OFF_STATUS_UPPER, d, r);
         if (k == 0)
            check("status before commit", d, SR2_RESET);
         u_nand.pulse(1'b1);
         rd(OFF_STATUS_UPPER, d, r);
         check("sector flags", d, ef);
         // software reads back every parity word to keep it in the spare area
         foreach (sq[j])
         begin
            rd(paddr(j + 1), d, r);
            if (cts[k] != 3'h3 && (cts[k] != CT_PAGE || j == 0))
               check("parity word", d, exp_pr(cts[k], sq[j]));
         end
      end
      wr(OFF_MODE, 32'h00000004, 4'h1, r);
      for (int c = 0; c < 5; c++)
      begin
         u_nand.send_rs({3'(c), 1'b0});
         rd(OFF_STATUS_UPPER, d, r);
         check("rs count", d, {29'h0, 3'(c)});
      end
      u_nand.send_rs({3'($urandom), 1'b1});
      rd(OFF_STATUS_UPPER, d, r);
      check("rs multi", d, 32'h00000008);
      u_nand.pulse(1'b0);
      rd(OFF_STATUS_UPPER, d, r);
      check("rs after command", d, SR2_RESET);
      u_nand.send_rs({3'h2, 1'b1});
      wr(OFF_MODE, 32'h00000100, 4'h2, r);
      rd(OFF_STATUS_UPPER, d, r);
      check("rs after soft reset", d, SR2_RESET);
      check("type kept", {29'h0, ctype}, 32'h00000004);
      end_of_test();
   end
endmodule
